// ===== dv/dao_cap_model.sv
// capture side model latching one channel's words
`timescale 1ns/1ps
`default_nettype none
module dao_cap
    import dao_pkg::*;
(
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic rstn_i,
    // pins of one channel
    input wire logic [CODE_W-1:0] data_i,
    input wire logic data_oe_i,
    input wire logic ovr_i,
    input wire logic strobe_i,
    // latched word and count
    output logic [CODE_W:0] word_o,
    output logic [15:0] count_o
);
    logic [CODE_W-1:0] bus_r;
    logic [CODE_W-1:0] pin_w;
    // an undriven bus toggles every cycle instead of keeping its value
    assign pin_w = data_oe_i ? data_i : ~bus_r;
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            bus_r <= '0;
            word_o <= '0;
            count_o <= '0;
        end else begin
            bus_r <= pin_w;
            if (strobe_i) begin
                word_o <= {ovr_i, pin_w};
                count_o <= count_o + 16'h1;
            end
        end
    end
endmodule : dao_cap
`default_nettype wire

// ===== dv/dao_top_assertions.sv
// port checks of the dual converter output block
`timescale 1ns/1ps
`default_nettype none
module dao_chk
    import dao_pkg::*;
(
    // clock, reset and pins
    input wire logic sys_clk_i,
    input wire logic rstn_i,
    input wire dao_raw_t chan_a_raw_i,
    input wire dao_raw_t chan_b_raw_i,
    input wire logic chan_a_oe_n_i,
    input wire logic chan_b_oe_n_i,
    input wire logic range_sel_i,
    input wire logic reference_source_choice_i,
    input wire logic drain_hold_i,
    // outputs
    input wire logic [CODE_W-1:0] chan_a_data_o,
    input wire logic chan_a_data_oe_o,
    input wire logic chan_a_over_range_flag_o,
    input wire logic chan_a_sample_valid_strobe_o,
    input wire logic [CODE_W-1:0] chan_b_data_o,
    input wire logic chan_b_data_oe_o,
    input wire logic chan_b_over_range_flag_o,
    input wire logic chan_b_sample_valid_strobe_o,
    input wire logic reference_ext_o,
    input wire logic range_wide_o
);
    logic held_r;
    logic [3:0] calm_r;
    logic calm;
    function automatic logic [CODE_W:0] conv(input dao_raw_t r);
        if (r > 14'sh07FF) return 13'h1FFF;
        if (r < -14'sh0800) return 13'h1000;
        return {1'b0, r[CODE_W-1:0] ^ MSB_FLIP};
    endfunction : conv
    // latency is only fixed while no hold has happened since reset
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            held_r <= 1'b0;
            calm_r <= 4'h0;
        end else begin
            held_r <= held_r | drain_hold_i;
            calm_r <= range_wide_o ? 4'h0 : calm_r + {3'h0, calm_r != 4'hF};
        end
    end
    assign calm = !held_r && !range_wide_o && calm_r >= 4'hA;
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!rstn_i);
    sequence s_held;
        drain_hold_i [*2];
    endsequence
    sequence s_oe_a_on;
        !chan_a_oe_n_i [*7];
    endsequence
    chk_code_a: assert property (calm |->
        {chan_a_over_range_flag_o, chan_a_data_o} == conv($past(chan_a_raw_i, 7)))
        else $error("channel a word wrong");
    chk_code_b: assert property (calm |->
        {chan_b_over_range_flag_o, chan_b_data_o} == conv($past(chan_b_raw_i, 7)))
        else $error("channel b word wrong");
    chk_strobe_run: assert property (calm |->
        chan_a_sample_valid_strobe_o && chan_b_sample_valid_strobe_o)
        else $error("strobe missing");
    chk_hold_stop: assert property (s_held |=>
        !chan_a_sample_valid_strobe_o && !chan_b_sample_valid_strobe_o)
        else $error("strobe during hold");
    chk_oe_off_a: assert property ($rose(chan_a_oe_n_i) |->
        ##[3:6] !chan_a_data_oe_o) else $error("channel a still driven");
    chk_oe_off_b: assert property ($rose(chan_b_oe_n_i) |->
        ##[3:6] !chan_b_data_oe_o) else $error("channel b still driven");
    chk_data_steady_a: assert property (!chan_a_sample_valid_strobe_o |->
        $stable(chan_a_data_o)) else $error("channel a word moved without strobe");
    chk_oe_on_a: assert property (s_oe_a_on |-> chan_a_data_oe_o)
        else $error("channel a not driven");
    chk_oe_on_b: assert property (!chan_b_oe_n_i [*7] |-> chan_b_data_oe_o)
        else $error("channel b not driven");
    chk_range_pin: assert property ($stable(range_sel_i) [*7] |->
        range_wide_o == range_sel_i) else $error("range level wrong");
    chk_ref_pin: assert property ($stable(reference_source_choice_i) [*7] |->
        reference_ext_o == reference_source_choice_i) else $error("reference level wrong");
endmodule : dao_chk
bind dao_top dao_chk u_chk (.*);
`default_nettype wire

// ===== dv/tb.sv
// self-checking bench of the dual converter output block
`timescale 1ns/1ps
`default_nettype none
module tb;
    import dao_pkg::*;
    logic sys_clk_i = 1'b0;
    logic rstn_i = 1'b0;
    dao_raw_t raw_a = '0;
    dao_raw_t raw_b = '0;
    logic oe_n_a = 1'b0;
    logic oe_n_b = 1'b0;
    logic rng = 1'b0;
    logic ref_sel = 1'b1;
    logic hold = 1'b0;
    logic [CODE_W-1:0] d_a, d_b;
    logic oe_a, oe_b, ov_a, ov_b, st_a, st_b, ref_ext, wide, f_rdy;
    logic [CODE_W:0] w_a, w_b;
    logic [15:0] n_a, n_b;
    int bad_count = 0;
    int samples_checked = 0;
    int tab[8] = '{2047, 2048, -2048, -2049, 3070, -3075, 1, -1};
    always #(SYS_CLK_PERIOD_NS / 2) sys_clk_i = ~sys_clk_i;
    dao_top dut (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .chan_a_raw_i(raw_a),
        .chan_b_raw_i(raw_b), .chan_a_oe_n_i(oe_n_a), .chan_b_oe_n_i(oe_n_b),
        .range_sel_i(rng), .reference_source_choice_i(ref_sel), .drain_hold_i(hold),
        .chan_a_data_o(d_a), .chan_a_data_oe_o(oe_a), .chan_a_over_range_flag_o(ov_a),
        .chan_a_sample_valid_strobe_o(st_a), .chan_b_data_o(d_b), .chan_b_data_oe_o(oe_b),
        .chan_b_over_range_flag_o(ov_b), .chan_b_sample_valid_strobe_o(st_b),
        .reference_ext_o(ref_ext), .range_wide_o(wide), .front_ready_o(f_rdy));
    dao_cap cap_a (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .data_i(d_a), .data_oe_i(oe_a),
        .ovr_i(ov_a), .strobe_i(st_a), .word_o(w_a), .count_o(n_a));
    dao_cap cap_b (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .data_i(d_b), .data_oe_i(oe_b),
        .ovr_i(ov_b), .strobe_i(st_b), .word_o(w_b), .count_o(n_b));
    task automatic wrap_up();
        $display("checks %0d bad %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : wrap_up
    task automatic check(input logic [12:0] seen, input logic [12:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD %0t seen %h want %h", $time, seen, exp);
        end
    endtask : check
    function automatic logic [12:0] want(input int r, input logic wd);
        int q;
        q = wd ? (r * 683) >>> 10 : r;
        if (q > 2047) return 13'h1FFF;
        if (q < -2048) return 13'h1000;
        return {1'b0, q[11:0] ^ 12'h800};
    endfunction : want
    task automatic wait_n(input int n);
        repeat (n) @(negedge sys_clk_i);
    endtask : wait_n
    task automatic t_reset();
        rstn_i = 1'b0;
        wait_n(2);
        check({oe_a, st_a, oe_b, st_b, ref_ext, wide, f_rdy, 6'h0}, 13'h0140);
        check({1'b0, d_a}, 13'h0);
        rstn_i = 1'b1;
        wait_n(3);
        check({11'h0, oe_a, oe_b}, 13'h3);
        $display("reset test done");
    endtask : t_reset
    // words launched at one falling edge show seven falling edges later
    task automatic run_seq(input logic wd);
        for (int n = 0; n < 16; n++) begin
            @(negedge sys_clk_i);
            if (n >= 7) begin
                check({ov_a, d_a}, want(tab[(n-7)%8], wd));
                check({ov_b, d_b}, want(-tab[(n-7)%8], wd));
                check({12'h0, st_a & st_b}, 13'h1);
            end
            if (n >= 8) check(w_a, want(tab[(n-8)%8], wd));
            raw_a = dao_raw_t'(tab[n%8]);
            raw_b = dao_raw_t'(-tab[n%8]);
        end
    endtask : run_seq
    task automatic t_narrow();
        run_seq(1'b0);
        $display("narrow range test done");
    endtask : t_narrow
    task automatic t_wide();
        rng = 1'b1;
        wait_n(8);
        check({12'h0, wide}, 13'h1);
        run_seq(1'b1);
        rng = 1'b0;
        wait_n(8);
        $display("wide range test done");
    endtask : t_wide
    task automatic t_enable();
        oe_n_a = 1'b1;
        wait_n(6);
        check({11'h0, oe_a, oe_b}, 13'h1);
        oe_n_a = 1'b0;
        oe_n_b = 1'b1;
        wait_n(6);
        check({11'h0, oe_a, oe_b}, 13'h2);
        oe_n_b = 1'b0;
        wait_n(8);
        $display("enable test done");
    endtask : t_enable
    task automatic t_ref();
        ref_sel = 1'b0;
        wait_n(6);
        check({12'h0, ref_ext}, 13'h0);
        ref_sel = 1'b1;
        wait_n(6);
        check({12'h0, ref_ext}, 13'h1);
        $display("reference test done");
    endtask : t_ref
    task automatic t_hold();
        int k = 0;
        logic [15:0] c;
        hold = 1'b1;
        wait_n(12);
        check({11'h0, st_a, st_b}, 13'h0);
        check({12'h0, f_rdy}, 13'h0);
        hold = 1'b0;
        while (st_a !== 1'b1 && k < 40) begin
            wait_n(1);
            k++;
        end
        if (k == 40) begin
            bad_count++;
            wrap_up();
        end
        c = n_b;
        wait_n(4);
        check(13'(n_b - c), 13'h4);
        $display("hold test done");
    endtask : t_hold
    initial begin
        t_reset();
        t_narrow();
        t_wide();
        t_enable();
        t_ref();
        t_hold();
        t_reset();
        wrap_up();
    end
endmodule : tb
`default_nettype wire

// ===== hw/dao_fifo.sv
// sample fifo with registered read data and registered ready
`timescale 1ns/1ps
`default_nettype none
module dao_fifo #(
    parameter int unsigned WIDTH = dao_pkg::WORD_W,
    parameter int unsigned DEPTH = dao_pkg::FIFO_DEPTH
) (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic rstn_i,
    // sample carrier
    dao_smp_if.fifo smp
);
    import dao_pkg::*;
    localparam int unsigned AW = $clog2(DEPTH);
    localparam logic [LVL_W-1:0] FULL_LVL = LVL_W'(DEPTH);
    localparam logic [LVL_W-1:0] LVL_ONE = LVL_W'(1);

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0] wptr_r;
    logic [AW-1:0] rptr_r;
    logic [LVL_W-1:0] cnt_r;
    logic [LVL_W-1:0] cnt_nxt;
    logic ready_r;
    logic rvalid_r;
    logic [WIDTH-1:0] rdata_r;
    wire do_wr = smp.wr_valid & ready_r;
    wire do_rd = smp.rd_ready & (cnt_r != '0);

    assign cnt_nxt = do_wr & ~do_rd ? cnt_r + LVL_ONE :
                     ~do_wr & do_rd ? cnt_r - LVL_ONE : cnt_r;

    always_ff @(posedge sys_clk_i) begin
        if (do_wr) begin
            mem_r[wptr_r] <= smp.wr_data;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            wptr_r <= '0;
            rptr_r <= '0;
            cnt_r <= '0;
            ready_r <= 1'b1;
            rvalid_r <= 1'b0;
            rdata_r <= '0;
        end else begin
            wptr_r <= do_wr ? AW'(wptr_r + 1'b1) : wptr_r;
            rptr_r <= do_rd ? AW'(rptr_r + 1'b1) : rptr_r;
            cnt_r <= cnt_nxt;
            ready_r <= cnt_nxt != FULL_LVL;
            rvalid_r <= do_rd;
            rdata_r <= do_rd ? mem_r[rptr_r] : rdata_r;
        end
    end

    assign smp.wr_ready = ready_r;
    assign smp.rd_valid = rvalid_r;
    assign smp.rd_data = rdata_r;
    assign smp.level = cnt_r;
endmodule : dao_fifo
`default_nettype wire

// ===== hw/dao_top.sv
// dual channel 12-bit converter digital output side
`timescale 1ns/1ps
`default_nettype none
module dao_top (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic rstn_i,
    // quantizer codes, same clock domain
    input wire dao_pkg::dao_raw_t chan_a_raw_i,
    input wire dao_pkg::dao_raw_t chan_b_raw_i,
    // static pins from the capture side
    input wire logic chan_a_oe_n_i,
    input wire logic chan_b_oe_n_i,
    input wire logic range_sel_i,
    input wire logic reference_source_choice_i,
    // drain stall from capture logic, same clock domain
    input wire logic drain_hold_i,
    // channel a outputs
    output logic [dao_pkg::CODE_W-1:0] chan_a_data_o,
    output logic chan_a_data_oe_o,
    output logic chan_a_over_range_flag_o,
    output logic chan_a_sample_valid_strobe_o,
    // channel b outputs
    output logic [dao_pkg::CODE_W-1:0] chan_b_data_o,
    output logic chan_b_data_oe_o,
    output logic chan_b_over_range_flag_o,
    output logic chan_b_sample_valid_strobe_o,
    // status
    output logic reference_ext_o,
    output logic range_wide_o,
    output logic front_ready_o
);
    import dao_pkg::*;

    // quantizer gain, clipping and offset binary coding
    function automatic logic [LANE_W-1:0] dao_convert(
        input dao_raw_t raw,
        input logic wide
    );
        logic signed [PROD_W-1:0] prod;
        logic signed [PROD_W-1:0] q;
        logic [LANE_W-1:0] res;
        prod = PROD_W'(raw) * (wide ? SCALE_3V : SCALE_2V);
        q = prod >>> SCALE_SH;
        if (q > CODE_MAX) begin
            res = {1'b1, CODE_TOP};
        end else if (q < CODE_MIN) begin
            res = {1'b1, CODE_BOT};
        end else begin
            res = {1'b0, q[CODE_W-1:0] ^ MSB_FLIP};
        end
        return res;
    endfunction : dao_convert

    // pin synchronisers: three stages, change taken when stages two and three agree
    logic [PIN_N-1:0] pin_s1_r;
    logic [PIN_N-1:0] pin_s2_r;
    logic [PIN_N-1:0] pin_s3_r;
    logic [PIN_N-1:0] pin_lvl_r;
    wire [PIN_N-1:0] pin_raw;
    wire [PIN_N-1:0] pin_agree = ~(pin_s2_r ^ pin_s3_r);
    wire [PIN_N-1:0] pin_lvl_nxt = (pin_agree & pin_s2_r) | (~pin_agree & pin_lvl_r);

    assign pin_raw[PIN_OE_A] = chan_a_oe_n_i;
    assign pin_raw[PIN_OE_B] = chan_b_oe_n_i;
    assign pin_raw[PIN_RANGE] = range_sel_i;
    assign pin_raw[PIN_REF] = reference_source_choice_i;

    // reset levels: enables on, range 2V, reference external as if pulled up
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pin_s1_r <= PIN_RST;
            pin_s2_r <= PIN_RST;
            pin_s3_r <= PIN_RST;
            pin_lvl_r <= PIN_RST;
        end else begin
            pin_s1_r <= pin_raw;
            pin_s2_r <= pin_s1_r;
            pin_s3_r <= pin_s2_r;
            pin_lvl_r <= pin_lvl_nxt;
        end
    end

    wire range_wide = pin_lvl_r[PIN_RANGE];

    // conversion stage: both channels registered on the same edge
    dao_smp_if smp ();
    dao_raw_t raw_in [CHANNELS];
    logic [WORD_W-1:0] conv_r;
    logic conv_valid_r;
    wire [WORD_W-1:0] conv_nxt;

    assign raw_in[0] = chan_a_raw_i;
    assign raw_in[1] = chan_b_raw_i;

    genvar gc;
    generate
        for (gc = 0; gc < CHANNELS; gc++) begin : g_conv
            assign conv_nxt[gc*LANE_W +: LANE_W] = dao_convert(raw_in[gc], range_wide);
        end
    endgenerate

    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            conv_r <= '0;
            conv_valid_r <= 1'b0;
        end else begin
            conv_r <= conv_nxt;
            conv_valid_r <= 1'b1;
        end
    end

    // fill control: reads start once enough words are queued for the fixed delay
    dao_state_e state_r;
    dao_state_e state_nxt;
    wire primed = (state_r == DAO_RUN) | (smp.level >= PRIME_LVL);

    always_comb begin
        case (state_r)
            DAO_FILL: state_nxt = primed ? DAO_RUN : DAO_FILL;
            DAO_RUN: state_nxt = DAO_RUN;
            default: state_nxt = DAO_FILL;
        endcase
    end

    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state_r <= DAO_FILL;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign smp.wr_valid = conv_valid_r;
    assign smp.wr_data = conv_r;
    assign smp.rd_ready = primed & ~drain_hold_i;

    dao_fifo #(
        .WIDTH(WORD_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .sys_clk_i(sys_clk_i),
        .rstn_i(rstn_i),
        .smp(smp)
    );

    // output stage per channel
    logic [CODE_W-1:0] dout_r [CHANNELS];
    logic [CHANNELS-1:0] oe_r;
    logic [CHANNELS-1:0] ovr_r;
    logic [CHANNELS-1:0] strobe_r;
    logic ref_r;
    logic wide_r;
    logic front_ready_r;
    wire [CHANNELS-1:0] en_n = {pin_lvl_r[PIN_OE_B], pin_lvl_r[PIN_OE_A]};

    generate
        for (gc = 0; gc < CHANNELS; gc++) begin : g_out
            wire [LANE_W-1:0] lane = smp.rd_data[gc*LANE_W +: LANE_W];
            always_ff @(posedge sys_clk_i or negedge rstn_i) begin
                if (!rstn_i) begin
                    dout_r[gc] <= '0;
                    ovr_r[gc] <= 1'b0;
                    strobe_r[gc] <= 1'b0;
                    oe_r[gc] <= 1'b0;
                end else begin
                    if (smp.rd_valid) begin
                        dout_r[gc] <= lane[CODE_W-1:0];
                        ovr_r[gc] <= lane[CODE_W];
                    end
                    strobe_r[gc] <= smp.rd_valid;
                    oe_r[gc] <= ~en_n[gc];
                end
            end
        end
    endgenerate

    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ref_r <= 1'b1;
            wide_r <= 1'b0;
            front_ready_r <= 1'b1;
        end else begin
            ref_r <= pin_lvl_r[PIN_REF];
            wide_r <= range_wide;
            front_ready_r <= smp.wr_ready;
        end
    end

    assign chan_a_data_o = dout_r[0];
    assign chan_a_data_oe_o = oe_r[0];
    assign chan_a_over_range_flag_o = ovr_r[0];
    assign chan_a_sample_valid_strobe_o = strobe_r[0];
    assign chan_b_data_o = dout_r[1];
    assign chan_b_data_oe_o = oe_r[1];
    assign chan_b_over_range_flag_o = ovr_r[1];
    assign chan_b_sample_valid_strobe_o = strobe_r[1];
    assign reference_ext_o = ref_r;
    assign range_wide_o = wide_r;
    assign front_ready_o = front_ready_r;
endmodule : dao_top
`default_nettype wire

// ===== hw/dao_top_unused_placeholder_none.sv
// no content
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// ===== inc/dao_pkg.sv
// constants and types of the dual converter output block
package dao_pkg;
    localparam int unsigned CHANNELS = 2;
    localparam int unsigned CODE_W = 12;
    localparam int unsigned RAW_W = 14;
    localparam int unsigned PROD_W = 26;
    localparam int unsigned LANE_W = CODE_W + 1;
    localparam int unsigned WORD_W = CHANNELS * LANE_W;
    localparam int unsigned FIFO_DEPTH = 8;
    localparam int unsigned LVL_W = 4;
    localparam int unsigned LATENCY = 6;
    localparam logic [LVL_W-1:0] PRIME_LVL = LVL_W'(LATENCY - 2);
    localparam int unsigned SYS_CLK_PERIOD_NS = 50;
    // gain of the quantizer for each full-scale range, fixed point
    localparam int unsigned SCALE_SH = 10;
    localparam logic signed [PROD_W-1:0] SCALE_2V = 26'sh0000400;
    localparam logic signed [PROD_W-1:0] SCALE_3V = 26'sh00002AB;
    localparam logic signed [PROD_W-1:0] CODE_MAX = 26'sh00007FF;
    localparam logic signed [PROD_W-1:0] CODE_MIN = -26'sh0000800;
    localparam logic [CODE_W-1:0] CODE_TOP = 12'hFFF;
    localparam logic [CODE_W-1:0] CODE_BOT = 12'h000;
    localparam logic [CODE_W-1:0] MSB_FLIP = 12'h800;
    // pin synchroniser lanes and their reset levels
    localparam int unsigned PIN_N = 4;
    localparam int unsigned PIN_OE_A = 0;
    localparam int unsigned PIN_OE_B = 1;
    localparam int unsigned PIN_RANGE = 2;
    localparam int unsigned PIN_REF = 3;
    localparam logic [PIN_N-1:0] PIN_RST = 4'h8;
    typedef logic [CODE_W-1:0] dao_code_t;
    typedef logic signed [RAW_W-1:0] dao_raw_t;
    typedef enum logic [0:0] {
        DAO_FILL = 1'b0,
        DAO_RUN = 1'b1
    } dao_state_e;
endpackage : dao_pkg

// ===== inc/dao_smp_if.sv
// sample word carrier between the converter core and its fifo
`timescale 1ns/1ps
`default_nettype none
interface dao_smp_if;
    import dao_pkg::*;
    logic wr_valid;
    logic wr_ready;
    logic [WORD_W-1:0] wr_data;
    logic rd_ready;
    logic rd_valid;
    logic [WORD_W-1:0] rd_data;
    logic [LVL_W-1:0] level;
    modport core (
        output wr_valid, wr_data, rd_ready,
        input wr_ready, rd_valid, rd_data, level
    );
    modport fifo (
        input wr_valid, wr_data, rd_ready,
        output wr_ready, rd_valid, rd_data, level
    );
endinterface : dao_smp_if
`default_nettype wire
